// ===== core/bram_pkg.sv
// shared constants and types for the embedded block ram
`default_nettype none
package bram_pkg;

    // ************************************************
    // storage geometry
    // ************************************************
    localparam int           CAP_BITS    = 18432;  // 18 Kbit including parity positions
    localparam int           WORD_BITS   = 36;
    localparam int           DEPTH_WORDS = 512;
    localparam int           LANE_BITS   = 9;
    localparam int           LANES       = 4;
    localparam int           ADDR_W      = 14;
    localparam logic [8:0]   LAST_WORD   = 9'h1FF;
    localparam logic [8:0]   CNT_RST     = 9'h000;
    localparam logic [35:0]  DATA_RST    = 36'h0_0000_0000;
    localparam logic [35:0]  ALL_ONES    = 36'hF_FFFF_FFFF;

    // ************************************************
    // configuration and sequencer types
    // ************************************************
    typedef enum logic [1:0] {
        MODE_SINGLE      = 2'b00,
        MODE_TRUE_DUAL   = 2'b01,
        MODE_PSEUDO_DUAL = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        WIDTH_1  = 3'b000,
        WIDTH_2  = 3'b001,
        WIDTH_4  = 3'b010,
        WIDTH_9  = 3'b011,
        WIDTH_18 = 3'b100,
        WIDTH_36 = 3'b101
    } width_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN  = 2'b01,
        ST_SAVE = 2'b10
    } state_t;

    localparam mode_t  MODE_RST  = MODE_SINGLE;
    localparam width_t WIDTH_RST = WIDTH_1;

    // zero marks an illegal width code
    function automatic logic [5:0] widthBits(input logic [2:0] w);
        unique case (w)
            WIDTH_1:  widthBits = 6'h01;
            WIDTH_2:  widthBits = 6'h02;
            WIDTH_4:  widthBits = 6'h04;
            WIDTH_9:  widthBits = 6'h09;
            WIDTH_18: widthBits = 6'h12;
            WIDTH_36: widthBits = 6'h24;
            default:  widthBits = 6'h00;
        endcase
    endfunction : widthBits

    function automatic logic [3:0] addrBits(input logic [2:0] w);
        unique case (w)
            WIDTH_1:  addrBits = 4'hE;
            WIDTH_2:  addrBits = 4'hD;
            WIDTH_4:  addrBits = 4'hC;
            WIDTH_9:  addrBits = 4'hB;
            WIDTH_18: addrBits = 4'hA;
            WIDTH_36: addrBits = 4'h9;
            default:  addrBits = 4'h0;
        endcase
    endfunction : addrBits

endpackage : bram_pkg
`default_nettype wire

// ===== core/shadow_if.sv
// word port between the ram core and its nonvolatile shadow store
`timescale 1ns/1ps
`default_nettype none
interface shadow_if;
    logic [8:0]  addr;
    logic        wrEn;
    logic [35:0] wrData;
    logic [35:0] rdData;

    modport ctrl  (output addr, output wrEn, output wrData, input rdData);
    modport store (input addr, input wrEn, input wrData, output rdData);
endinterface : shadow_if
`default_nettype wire

// ===== core/shadow_store.sv
// nonvolatile shadow copy of the ram contents
`timescale 1ns/1ps
`default_nettype none
module shadow_store (
    input  wire logic  clk,
    shadow_if.store    sh
);
    // no reset: contents survive reset and reconfiguration
    logic [35:0] cells [bram_pkg::DEPTH_WORDS];

    always_ff @(posedge clk) begin
        if (sh.wrEn) begin
            cells[sh.addr] <= sh.wrData;
        end
    end

    assign sh.rdData = cells[sh.addr];
endmodule : shadow_store
`default_nettype wire

// ===== core/embedded_block_ram.sv
// 18 Kbit block ram with two ports, mixed widths and a shadow copy
// Functional notes
// - 18 Kbit array with registers on input and output paths.
// - Modes: single port, true dual port, pseudo dual port.
// - Widths 1, 2, 4, 9, 18; 36 only outside true dual port.
// - Each port has its own width in multi-port modes.
// - Bits fill word 0 low to high, then word 1, for every port.
// - Optional parity bit stored beside each data byte.
// - Byte enables limit writes at 18 and 36 bit widths.
// - Shadow contents load into ram at power up and reconfiguration.
// - Ram contents can be copied back into the shadow store.
`timescale 1ns/1ps
`default_nettype none
module embedded_block_ram #(
    parameter bit GEN_PARITY = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [1:0]    cfgMode,
    input  wire logic [2:0]    cfgWidthA,
    input  wire logic [2:0]    cfgWidthB,
    input  wire logic          reconfig,
    input  wire logic          saveReq,
    input  wire logic          progWe,
    input  wire logic [8:0]    progAddr,
    input  wire logic [35:0]   progData,
    input  wire logic          ceA,
    input  wire logic          weA,
    input  wire logic [13:0]   addrA,
    input  wire logic [35:0]   dinA,
    input  wire logic [3:0]    beA,
    output logic      [35:0]   doutA,
    input  wire logic          ceB,
    input  wire logic          weB,
    input  wire logic [13:0]   addrB,
    input  wire logic [35:0]   dinB,
    input  wire logic [3:0]    beB,
    output logic      [35:0]   doutB,
    output logic               busy,
    output logic               cfgError
);
    if (bram_pkg::DEPTH_WORDS * bram_pkg::WORD_BITS != bram_pkg::CAP_BITS) begin : g_bad_geom
        $error("array geometry does not give the storage size");
    end

    // ************************************************
    // configuration and sequencer state
    // ************************************************
    bram_pkg::mode_t   cfgMode_r;
    bram_pkg::width_t  cfgWidth_r [2];
    bram_pkg::state_t  state_r;
    bram_pkg::state_t  state_nxt;
    logic [8:0]        cnt_r;
    logic [8:0]        cnt_nxt;
    logic              busy_r;
    logic              cfgError_r;
    wire               cfgErrNxt;
    wire               run;
    wire               modeBad;
    wire               wideInTdp;
    logic [35:0] mem [bram_pkg::DEPTH_WORDS];
    // per-port input and output registers
    logic        accR_r  [2];
    logic        weR_r   [2];
    logic [13:0] addrR_r [2];
    logic [35:0] dinR_r  [2];
    logic [3:0]  beR_r   [2];
    logic [35:0] readRaw_r [2];
    logic [35:0] dout_r    [2];
    wire        ceIn   [2];
    wire        weIn   [2];
    wire [13:0] addrIn [2];
    wire [35:0] dinIn  [2];
    wire [3:0]  beIn   [2];
    wire [5:0]  wBits   [2];
    wire [13:0] addrM   [2];
    wire [19:0] bitPos  [2];
    wire [8:0]  idx     [2];
    wire [5:0]  off     [2];
    wire [35:0] fieldM  [2];
    wire [35:0] laneEn  [2];
    wire [35:0] dPar    [2];
    wire [35:0] wMask   [2];
    wire [35:0] wVal    [2];
    wire [35:0] rdField [2];
    wire [35:0] newWord [2];
    wire        wrGo    [2];
    wire        rdGo    [2];
    wire        canWr   [2];
    wire        canRd   [2];
    wire [35:0] baseB;
    shadow_if sh ();
    shadow_store u_shadow (
        .clk (clk),
        .sh  (sh.store)
    );

    assign ceIn[0]   = ceA;
    assign ceIn[1]   = ceB;
    assign weIn[0]   = weA;
    assign weIn[1]   = weB;
    assign addrIn[0] = addrA;
    assign addrIn[1] = addrB;
    assign dinIn[0]  = dinA;
    assign dinIn[1]  = dinB;
    assign beIn[0]   = beA;
    assign beIn[1]   = beB;

    // ************************************************
    // configuration check
    // ************************************************
    assign modeBad   = (cfgMode == 2'b11);
    assign wideInTdp = (cfgMode == bram_pkg::MODE_TRUE_DUAL)
                     && (cfgWidthA == bram_pkg::WIDTH_36 || cfgWidthB == bram_pkg::WIDTH_36);
    assign cfgErrNxt = modeBad || wideInTdp
                     || bram_pkg::widthBits(cfgWidthA) == 6'h00
                     || bram_pkg::widthBits(cfgWidthB) == 6'h00;
    assign run = (state_r == bram_pkg::ST_RUN);

    always_ff @(posedge clk) begin
        if (rst) begin
            cfgMode_r     <= bram_pkg::MODE_RST;
            cfgWidth_r[0] <= bram_pkg::WIDTH_RST;
            cfgWidth_r[1] <= bram_pkg::WIDTH_RST;
            cfgError_r    <= 1'b0;
        end else begin
            cfgMode_r     <= bram_pkg::mode_t'(cfgMode);
            cfgWidth_r[0] <= bram_pkg::width_t'(cfgWidthA);
            cfgWidth_r[1] <= bram_pkg::width_t'(cfgWidthB);
            cfgError_r    <= cfgErrNxt;
        end
    end

    // ************************************************
    // port datapaths
    // ************************************************
    for (genvar p = 0; p < 2; p++) begin : g_port
        always_ff @(posedge clk) begin
            if (rst) begin
                accR_r[p]    <= 1'b0;
                weR_r[p]     <= 1'b0;
                addrR_r[p]   <= 14'h0000;
                dinR_r[p]    <= bram_pkg::DATA_RST;
                beR_r[p]     <= 4'h0;
                readRaw_r[p] <= bram_pkg::DATA_RST;
                dout_r[p]    <= bram_pkg::DATA_RST;
            end else begin
                accR_r[p] <= ceIn[p];
                if (ceIn[p]) begin
                    weR_r[p]   <= weIn[p];
                    addrR_r[p] <= addrIn[p];
                    dinR_r[p]  <= dinIn[p];
                    beR_r[p]   <= beIn[p];
                end
                if (rdGo[p]) begin
                    readRaw_r[p] <= rdField[p];
                end
                dout_r[p] <= readRaw_r[p];
            end
        end

        assign wBits[p]  = bram_pkg::widthBits(cfgWidth_r[p]);
        assign addrM[p]  = addrR_r[p] & ~(14'h3FFF << bram_pkg::addrBits(cfgWidth_r[p]));
        // linear bit position keeps one ordering for every width
        assign bitPos[p] = 20'(addrM[p]) * 20'(wBits[p]);
        assign idx[p]    = 9'(bitPos[p] / 20'(bram_pkg::WORD_BITS));
        assign off[p]    = 6'(bitPos[p] % 20'(bram_pkg::WORD_BITS));
        assign fieldM[p] = bram_pkg::ALL_ONES >> (6'(bram_pkg::WORD_BITS) - wBits[p]);

        for (genvar l = 0; l < bram_pkg::LANES; l++) begin : g_lane
            localparam int B = l * bram_pkg::LANE_BITS;
            assign laneEn[p][B +: 9] = (wBits[p] >= 6'h12) ? {9{beR_r[p][l]}} : 9'h1FF;
            assign dPar[p][B +: 8]   = dinR_r[p][B +: 8];
            assign dPar[p][B + 8]    = (GEN_PARITY && wBits[p] >= 6'h09)
                                     ? ^dinR_r[p][B +: 8] : dinR_r[p][B + 8];
        end

        assign wMask[p]   = (fieldM[p] & laneEn[p]) << off[p];
        assign wVal[p]    = dPar[p] << off[p];
        assign rdField[p] = (mem[idx[p]] >> off[p]) & fieldM[p];
        assign wrGo[p]    = run && accR_r[p] && weR_r[p] && canWr[p];
        assign rdGo[p]    = run && accR_r[p] && !weR_r[p] && canRd[p];
    end
    // port A is the write side in pseudo dual mode, B the read side
    assign canWr[0] = !cfgError_r;
    assign canRd[0] = !cfgError_r && cfgMode_r != bram_pkg::MODE_PSEUDO_DUAL;
    assign canWr[1] = !cfgError_r && cfgMode_r == bram_pkg::MODE_TRUE_DUAL;
    assign canRd[1] = !cfgError_r && cfgMode_r != bram_pkg::MODE_SINGLE;

    // same-word writes merge, B wins only on overlapping bits
    assign newWord[0] = (mem[idx[0]] & ~wMask[0]) | (wVal[0] & wMask[0]);
    assign baseB      = (wrGo[0] && idx[0] == idx[1]) ? newWord[0] : mem[idx[1]];
    assign newWord[1] = (baseB & ~wMask[1]) | (wVal[1] & wMask[1]);

    always_ff @(posedge clk) begin
        if (state_r == bram_pkg::ST_LOAD) begin
            mem[cnt_r] <= sh.rdData;
        end else begin
            if (wrGo[0]) begin
                mem[idx[0]] <= newWord[0];
            end
            if (wrGo[1]) begin
                mem[idx[1]] <= newWord[1];
            end
        end
    end

    // ************************************************
    // shadow load and save sequencer
    // ************************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            bram_pkg::ST_LOAD, bram_pkg::ST_SAVE: begin
                cnt_nxt = cnt_r + 9'h001;
                if (cnt_r == bram_pkg::LAST_WORD) begin
                    state_nxt = bram_pkg::ST_RUN;
                    cnt_nxt   = bram_pkg::CNT_RST;
                end
            end
            bram_pkg::ST_RUN: begin
                if (reconfig) begin
                    state_nxt = bram_pkg::ST_LOAD;
                end else if (saveReq) begin
                    state_nxt = bram_pkg::ST_SAVE;
                end
            end
            default: begin
                state_nxt = bram_pkg::ST_LOAD;
                cnt_nxt   = bram_pkg::CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= bram_pkg::ST_LOAD;
            cnt_r   <= bram_pkg::CNT_RST;
            busy_r  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= (state_nxt != bram_pkg::ST_RUN);
        end
    end

    // programming reaches the shadow only while idle
    assign sh.addr   = run ? progAddr : cnt_r;
    assign sh.wrEn   = (state_r == bram_pkg::ST_SAVE) || (run && progWe);
    assign sh.wrData = run ? progData : mem[cnt_r];

    assign doutA    = dout_r[0];
    assign doutB    = dout_r[1];
    assign busy     = busy_r;
    assign cfgError = cfgError_r;

    // ************************************************
    // checks
    // ************************************************
    chk_read_latency: assert property (
        @(posedge clk) disable iff (rst) rdGo[0] |=> ##1 doutA == $past(rdField[0], 2))
        else $error("port A read data not at output two cycles later");
    chk_pseudo_readonly: assert property (
        @(posedge clk) disable iff (rst)
        cfgMode_r != bram_pkg::MODE_TRUE_DUAL |-> !wrGo[1])
        else $error("port B wrote outside true dual mode");
    chk_wide_tdp: assert property (
        @(posedge clk) disable iff (rst)
        $past(wideInTdp) && !$past(rst) |-> cfgError_r && !wrGo[0] && !wrGo[1])
        else $error("36 bit true dual setup not refused");
    chk_bit_order: assert property (
        @(posedge clk) disable iff (rst) off[1] < 6'h24
        && 20'(idx[1]) * 20'h24 + 20'(off[1]) == 20'(addrM[1]) * 20'(wBits[1]))
        else $error("port B bit position misplaced");
    chk_byte_lanes: assert property (
        @(posedge clk) disable iff (rst) wrGo[0] && !wrGo[1] |=>
        (mem[$past(idx[0])] & ~$past(wMask[0])) === ($past(mem[idx[0]]) & ~$past(wMask[0])))
        else $error("write touched bits outside enabled lanes");
    chk_parity_bit: assert property (
        @(posedge clk) disable iff (rst) wBits[0] >= 6'h09
        |-> dPar[0][8] == (GEN_PARITY ? ^dinR_r[0][7:0] : dinR_r[0][8]))
        else $error("stored parity does not match byte");
    chk_load_copy: assert property (
        @(posedge clk) disable iff (rst)
        state_r == bram_pkg::ST_LOAD |=> mem[$past(cnt_r)] === $past(sh.rdData))
        else $error("shadow word not loaded into ram");
    chk_load_end: assert property (
        @(posedge clk) disable iff (rst)
        state_r == bram_pkg::ST_LOAD && cnt_r == bram_pkg::LAST_WORD |=> run && !busy_r)
        else $error("load did not finish after last word");
    chk_save_start: assert property (
        @(posedge clk) disable iff (rst) run && saveReq && !reconfig
        |=> state_r == bram_pkg::ST_SAVE && busy_r && cnt_r == 9'h000 ##1 sh.wrEn)
        else $error("save request did not start copy");
    chk_capture_hold: assert property (
        @(posedge clk) disable iff (rst) !ceB |=> $stable(addrR_r[1]) && !accR_r[1])
        else $error("port B captured without enable");
endmodule : embedded_block_ram
`default_nettype wire

// ===== testbench/fabric_port.sv
// user fabric logic that drives one memory port
`timescale 1ns/1ps
`default_nettype none
module fabric_port (
    input  wire logic        clk,
    output logic             ce,
    output logic             we,
    output logic [13:0]      addr,
    output logic [35:0]      din,
    output logic [3:0]       be,
    input  wire logic [35:0] dout
);
    initial begin
        ce   = 1'b0;
        we   = 1'b0;
        addr = 14'h0000;
        din  = 36'h0_0000_0000;
        be   = 4'h0;
    end

    // ************************************************
    // one request, held for exactly one capture edge
    // ************************************************
    task automatic access(input logic c, input logic w, input logic [13:0] a,
                          input logic [35:0] d, input logic [3:0] b);
        @(posedge clk);
        ce   <= c;
        we   <= w;
        addr <= a;
        din  <= d;
        be   <= b;
        @(posedge clk);
        ce   <= 1'b0;
        we   <= 1'b0;
        // released address, data and byte-enable lines never keep the last value, so stale capture shows up
        addr <= ~a;
        din  <= ~d;
        be   <= ~b;
    endtask : access

    // read data is settled two edges after the capture edge
    task automatic read(input logic [13:0] a, output logic [35:0] d);
        access(1'b1, 1'b0, a, 36'h0_0000_0000, 4'h0);
        repeat (2) @(posedge clk);
        #1;
        d = dout;
    endtask : read
endmodule : fabric_port
`default_nettype wire

// ===== testbench/tb.sv
// self-checking testbench for the embedded block ram
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk;
    logic        rst;
    logic [1:0]  cfgMode;
    logic [2:0]  cfgWidthA;
    logic [2:0]  cfgWidthB;
    logic        reconfig;
    logic        saveReq;
    logic        progWe;
    logic [8:0]  progAddr;
    logic [35:0] progData;
    logic        ceA, weA, ceB, weB;
    logic [13:0] addrA, addrB;
    logic [35:0] dinA, dinB, doutA, doutB;
    logic [3:0]  beA, beB;
    logic        busy;
    logic        cfgError;
    int          nErrors;
    int          nChecks;

    embedded_block_ram #(.GEN_PARITY(1'b0)) u_embedded_block_ram (
        .clk(clk), .rst(rst), .cfgMode(cfgMode), .cfgWidthA(cfgWidthA),
        .cfgWidthB(cfgWidthB), .reconfig(reconfig), .saveReq(saveReq),
        .progWe(progWe), .progAddr(progAddr), .progData(progData),
        .ceA(ceA), .weA(weA), .addrA(addrA), .dinA(dinA), .beA(beA), .doutA(doutA),
        .ceB(ceB), .weB(weB), .addrB(addrB), .dinB(dinB), .beB(beB), .doutB(doutB),
        .busy(busy), .cfgError(cfgError));
    fabric_port u_port_a (.clk(clk), .ce(ceA), .we(weA), .addr(addrA), .din(dinA),
        .be(beA), .dout(doutA));
    fabric_port u_port_b (.clk(clk), .ce(ceB), .we(weB), .addr(addrB), .din(dinB),
        .be(beB), .dout(doutB));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ************************************************
    // shared helpers
    // ************************************************
    task automatic completeRun;
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : completeRun

    task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic waitIdle;
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 600) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk("busy", {35'h0, busy}, 36'h0_0000_0000);
    endtask : waitIdle

    task automatic setCfg(input logic [1:0] m, input logic [2:0] wa, input logic [2:0] wb);
        @(posedge clk);
        cfgMode   <= m;
        cfgWidthA <= wa;
        cfgWidthB <= wb;
        repeat (2) @(posedge clk);
        #1;
    endtask : setCfg

    // busy must rise at the very edge that takes the request
    task automatic startCopy(input bit save);
        @(posedge clk);
        saveReq  <= save;
        reconfig <= ~save;
        @(posedge clk);
        saveReq  <= 1'b0;
        reconfig <= 1'b0;
        #1;
        chk("busyRise", {35'h0, busy}, 36'h0_0000_0001);
        waitIdle();
    endtask : startCopy

    task automatic wr(input bit pb, input logic [13:0] a, input logic [35:0] d,
                      input logic [3:0] b);
        if (pb) u_port_b.access(1'b1, 1'b1, a, d, b);
        else u_port_a.access(1'b1, 1'b1, a, d, b);
    endtask : wr

    task automatic rd(input bit pb, input logic [13:0] a, input logic [35:0] exp);
        logic [35:0] d;
        if (pb) u_port_b.read(a, d);
        else u_port_a.read(a, d);
        chk(pb ? "doutB" : "doutA", d, exp);
    endtask : rd

    // ************************************************
    // scenarios
    // ************************************************
    task automatic testShadowLoad;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            progWe   <= 1'b1;
            progAddr <= 9'(k);
            progData <= 36'h1_1111_1111 * k + 36'h0_0000_00A5;
            @(posedge clk);
            progWe   <= 1'b0;
        end
        startCopy(1'b0);
        for (int k = 0; k < 4; k++) begin
            rd(0, 14'(k), 36'h1_1111_1111 * k + 36'h0_0000_00A5);
        end
        $display("test shadow load done");
    endtask : testShadowLoad

    task automatic testByteEnable;
        wr(0, 14'h0009, bram_pkg::ALL_ONES, 4'hF);
        wr(0, 14'h0009, 36'h0_0000_0000, 4'h1);
        rd(0, 14'h0009, 36'hF_FFFF_FE00);
        setCfg(2'b00, 3'b100, 3'b100);
        wr(0, 14'h0014, 36'h0_0003_FFFF, 4'h3);
        wr(0, 14'h0014, 36'h0_0000_0000, 4'h2);
        // disabled lane keeps the parity position too
        rd(0, 14'h0014, 36'h0_0000_01FF);
        u_port_a.access(1'b0, 1'b1, 14'h0014, 36'h0_0000_0000, 4'h3);
        rd(0, 14'h0014, 36'h0_0000_01FF);
        $display("test byte enable done");
    endtask : testByteEnable

    task automatic testMixedWidth;
        setCfg(2'b01, 3'b100, 3'b011);
        wr(0, 14'h0002, 36'h0_0001_2345, 4'h3);
        rd(1, 14'h0004, 36'h0_0000_0145);
        rd(1, 14'h0005, 36'h0_0000_0091);
        setCfg(2'b01, 3'b100, 3'b000);
        rd(1, 14'h0024, 36'h0_0000_0001);
        rd(1, 14'h0025, 36'h0_0000_0000);
        wr(1, 14'h0027, 36'h0_0000_0001, 4'h0);
        rd(1, 14'h0026, 36'h0_0000_0001);
        rd(0, 14'h0002, 36'h0_0001_234D);
        setCfg(2'b01, 3'b100, 3'b010);
        rd(1, 14'h0009, 36'h0_0000_000D);
        setCfg(2'b01, 3'b100, 3'b001);
        rd(1, 14'h0013, 36'h0_0000_0003);
        $display("test mixed width done");
    endtask : testMixedWidth

    task automatic testModes;
        setCfg(2'b10, 3'b101, 3'b101);
        wr(0, 14'h0005, 36'h9_8765_4321, 4'hF);
        rd(1, 14'h0005, 36'h9_8765_4321);
        rd(0, 14'h0005, 36'h0_0001_234D);
        wr(1, 14'h0005, 36'h0_0BAD_0BAD, 4'hF);
        rd(1, 14'h0005, 36'h9_8765_4321);
        setCfg(2'b00, 3'b101, 3'b101);
        rd(1, 14'h0000, 36'h9_8765_4321);
        rd(0, 14'h0005, 36'h9_8765_4321);
        $display("test modes done");
    endtask : testModes

    task automatic testSave;
        wr(0, 14'h0007, 36'h5_0505_0505, 4'hF);
        startCopy(1'b1);
        wr(0, 14'h0007, 36'hA_FAFA_FAFA, 4'hF);
        rd(0, 14'h0007, 36'hA_FAFA_FAFA);
        startCopy(1'b0);
        rd(0, 14'h0007, 36'h5_0505_0505);
        $display("test save done");
    endtask : testSave

    // fifo built outside the ram: pointers and fill count live in the fabric
    task automatic testFifo;
        logic [8:0] wrPtr;
        logic [8:0] rdPtr;
        int         fill;
        wrPtr = 9'h000;
        rdPtr = 9'h000;
        fill  = 0;
        setCfg(2'b10, 3'b101, 3'b101);
        for (int k = 0; k < 3; k++) begin
            wr(0, 14'(wrPtr), 36'h0_0000_0C00 + 36'(k), 4'hF);
            wrPtr = wrPtr + 9'h001;
            fill++;
        end
        while (fill > 0) begin
            rd(1, 14'(rdPtr), 36'h0_0000_0C00 + 36'(rdPtr));
            rdPtr = rdPtr + 9'h001;
            fill--;
        end
        $display("test fifo done");
    endtask : testFifo

    task automatic testCfgError;
        setCfg(2'b01, 3'b101, 3'b100);
        chk("cfgError", {35'h0, cfgError}, 36'h0_0000_0001);
        setCfg(2'b10, 3'b101, 3'b101);
        chk("cfgError", {35'h0, cfgError}, 36'h0_0000_0000);
        setCfg(2'b11, 3'b000, 3'b000);
        chk("cfgError", {35'h0, cfgError}, 36'h0_0000_0001);
        setCfg(2'b00, 3'b110, 3'b000);
        chk("cfgError", {35'h0, cfgError}, 36'h0_0000_0001);
        setCfg(2'b00, 3'b101, 3'b101);
        chk("cfgError", {35'h0, cfgError}, 36'h0_0000_0000);
        $display("test config error done");
    endtask : testCfgError

    // ************************************************
    // main sequence and watchdog
    // ************************************************
    initial begin
        nErrors   = 0;
        nChecks   = 0;
        rst       = 1'b1;
        cfgMode   = 2'b00;
        cfgWidthA = 3'b101;
        cfgWidthB = 3'b101;
        reconfig  = 1'b0;
        saveReq   = 1'b0;
        progWe    = 1'b0;
        progAddr  = 9'h000;
        progData  = 36'h0_0000_0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("busy", {35'h0, busy}, 36'h0_0000_0001);
        chk("doutA", doutA, 36'h0_0000_0000);
        waitIdle();
        chk("cfgError", {35'h0, cfgError}, 36'h0_0000_0000);
        testShadowLoad();
        testByteEnable();
        testMixedWidth();
        testModes();
        testSave();
        testFifo();
        testCfgError();
        completeRun();
    end

    // four copies of 513 cycles plus short traffic stay well inside this
    initial begin
        #320000;
        nErrors++;
        completeRun();
    end
endmodule : tb
`default_nettype wire
